// file: hdl/pifb_pkg.sv
package pifb_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_GRP = 8;
    localparam int NUM_CAP = 2;
    localparam int ADDR_W  = 8;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_MASK      = 8'h08;
    localparam logic [7:0] ADDR_EN_BASE   = 8'h20;
    localparam logic [7:0] ADDR_FLAG_BASE = 8'h40;

    // ----------------------------------------------------------------
    // field layouts and reset values
    // ----------------------------------------------------------------
    localparam int         GLOBAL_EN_BIT = 7;
    localparam int         PERIPH_EN_BIT = 6;
    localparam logic [7:0] CTRL_IMPL = 8'hC1;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] FLAG_RST  = 8'h00;
    localparam logic [7:0] EN_RST    = 8'h00;
    localparam logic [7:0] STAT_RST  = 8'h00;
    localparam logic [7:0] MASK_RST  = 8'h00;

    // implemented bits per flag/enable group, index = group number
    localparam logic [7:0] GRP_IMPL [NUM_GRP] = '{8'h31, 8'hC1, 8'h43, 8'h33,
                                                  8'h03, 8'hF1, 8'h03, 8'h31};
    localparam int CMP2_GRP  = 2;
    localparam int CMP2_BIT  = 1;
    localparam int CAP_GRP   = 6;
    localparam int MISC_GRP  = 7;
    localparam int MEM_BIT   = 5;
    localparam int OSC_BIT   = 4;
    localparam int WAVE_BIT  = 0;
    localparam int NUM_EXT   = 6;

    // ----------------------------------------------------------------
    // bus answers and modes
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        PIFB_MODE_OFF,
        PIFB_MODE_CAPTURE,
        PIFB_MODE_COMPARE,
        PIFB_MODE_PWM
    } pifb_mode_e;

endpackage

// file: hdl/pifb_flag_bank.sv
`timescale 1ns/10ps
module pifb_flag_bank #(
    parameter bit LARGE_VARIANT = 1'h1
) (
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    input  wire logic [pifb_pkg::ADDR_W-1:0]       awaddr,
    input  wire logic                              awvalid,
    output logic                                   awready,
    input  wire logic [31:0]                       wdata,
    input  wire logic [3:0]                        wstrb,
    input  wire logic                              wvalid,
    output logic                                   wready,
    output logic [1:0]                             bresp,
    output logic                                   bvalid,
    input  wire logic                              bready,
    input  wire logic [pifb_pkg::ADDR_W-1:0]       araddr,
    input  wire logic                              arvalid,
    output logic                                   arready,
    output logic [31:0]                            rdata,
    output logic [1:0]                             rresp,
    output logic                                   rvalid,
    input  wire logic                              rready,
    input  wire logic [8*pifb_pkg::NUM_EXT-1:0]    ext_evt,
    input  wire logic [2*pifb_pkg::NUM_CAP-1:0]    capture_unit_mode,
    input  wire logic [pifb_pkg::NUM_CAP-1:0]      capture_evt,
    input  wire logic [pifb_pkg::NUM_CAP-1:0]      match_evt,
    input  wire logic [pifb_pkg::NUM_CAP-1:0]      pwm_trail_evt,
    input  wire logic                              memory_done,
    input  wire logic                              osc_rollover,
    input  wire logic                              waveform_shutdown,
    output logic                                   core_irq_req,
    output logic                                   irq
);
    import pifb_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0]        flag_r [NUM_GRP];
    logic [7:0]        flag_nxt [NUM_GRP];
    logic [7:0]        en_r [NUM_GRP];
    logic [7:0]        en_nxt [NUM_GRP];
    logic [7:0]        impl [NUM_GRP];
    logic [7:0]        evt [NUM_GRP];
    logic [7:0]        ctrl_r, ctrl_nxt;
    logic [7:0]        status_r, status_nxt;
    logic [7:0]        mask_r, mask_nxt;
    logic              core_irq_r, core_irq_nxt;
    logic              irq_r, irq_nxt;
    logic [NUM_CAP-1:0] cap_hit;
    logic [NUM_GRP-1:0] wr_flag_hit;
    logic [NUM_GRP-1:0] wr_en_hit;
    logic [NUM_GRP-1:0] grp_hit;

    logic              aw_held_r, aw_held_nxt;
    logic [7:0]        awaddr_r, awaddr_nxt;
    logic              w_held_r, w_held_nxt;
    logic [7:0]        wdata_r, wdata_nxt;
    logic              wstrb0_r, wstrb0_nxt;
    logic              bvalid_r, bvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt;
    logic              rvalid_r, rvalid_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic [1:0]        rresp_r, rresp_nxt;

    logic              aw_take, w_take, ar_take, wr_go;
    logic [7:0]        wa, wd;
    logic              wb0, wr_ok, wr_ctrl, wr_mask;
    logic [7:0]        rd_val;
    logic              rd_ok, rd_status;

    // ----------------------------------------------------------------
    // event sources
    // ----------------------------------------------------------------

    // each capture unit reports only the event of its selected mode
    for (genvar u = 0; u < NUM_CAP; u++) begin : g_cap
        pifb_mode_e mode;
        assign mode = pifb_mode_e'(capture_unit_mode[2*u +: 2]);
        assign cap_hit[u] = (mode == PIFB_MODE_CAPTURE && capture_evt[u])
                         || (mode == PIFB_MODE_COMPARE && match_evt[u])
                         || (mode == PIFB_MODE_PWM && pwm_trail_evt[u]);
    end

    // event vectors per group, limited to implemented bits
    always_comb begin
        for (int g = 0; g < NUM_GRP; g++) begin
            impl[g] = GRP_IMPL[g];
            evt[g]  = 8'h00;
        end
        if (!LARGE_VARIANT) begin
            impl[CMP2_GRP][CMP2_BIT] = 1'h0;
        end
        for (int g = 0; g < NUM_EXT; g++) begin
            evt[g] = ext_evt[8*g +: 8];
        end
        evt[CAP_GRP][NUM_CAP-1:0] = cap_hit;
        evt[MISC_GRP][MEM_BIT]    = memory_done;
        evt[MISC_GRP][OSC_BIT]    = osc_rollover;
        evt[MISC_GRP][WAVE_BIT]   = waveform_shutdown;
        for (int g = 0; g < NUM_GRP; g++) begin
            evt[g] = evt[g] & impl[g];
        end
    end

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign awready = !aw_held_r && !bvalid_r;
    assign wready  = !w_held_r && !bvalid_r;
    assign arready = !rvalid_r;
    assign aw_take = awvalid && awready;
    assign w_take  = wvalid && wready;
    assign ar_take = arvalid && arready;
    // a write goes once address and data are both in hand, in either order
    assign wr_go   = (aw_held_r || awvalid) && (w_held_r || wvalid) && !bvalid_r;
    assign wa      = aw_held_r ? awaddr_r : awaddr;
    assign wd      = w_held_r ? wdata_r : wdata[7:0];
    assign wb0     = w_held_r ? wstrb0_r : wstrb[0];

    // write target select; status is read-only but answers okay
    always_comb begin
        wr_flag_hit = '0;
        wr_en_hit   = '0;
        wr_ctrl     = 1'h0;
        wr_mask     = 1'h0;
        wr_ok       = 1'h0;
        if (wa[1:0] == 2'h0) begin
            if (wa == ADDR_CTRL || wa == ADDR_STATUS || wa == ADDR_MASK) begin
                wr_ok = 1'h1;
            end
            if (wa[7:5] == ADDR_EN_BASE[7:5] || wa[7:5] == ADDR_FLAG_BASE[7:5]) begin
                wr_ok = 1'h1;
            end
            if (wr_go && wb0) begin
                wr_ctrl = (wa == ADDR_CTRL);
                wr_mask = (wa == ADDR_MASK);
                if (wa[7:5] == ADDR_EN_BASE[7:5]) begin
                    wr_en_hit[wa[4:2]] = 1'h1;
                end
                if (wa[7:5] == ADDR_FLAG_BASE[7:5]) begin
                    wr_flag_hit[wa[4:2]] = 1'h1;
                end
            end
        end
    end

    // read mux; unimplemented bits come back as zero
    always_comb begin
        rd_val    = 8'h00;
        rd_ok     = 1'h0;
        rd_status = 1'h0;
        if (araddr[1:0] == 2'h0) begin
            if (araddr == ADDR_CTRL) begin
                rd_val = ctrl_r;
                rd_ok  = 1'h1;
            end
            if (araddr == ADDR_STATUS) begin
                rd_val    = status_r;
                rd_ok     = 1'h1;
                rd_status = ar_take;
            end
            if (araddr == ADDR_MASK) begin
                rd_val = mask_r;
                rd_ok  = 1'h1;
            end
            if (araddr[7:5] == ADDR_EN_BASE[7:5]) begin
                rd_val = en_r[araddr[4:2]];
                rd_ok  = 1'h1;
            end
            if (araddr[7:5] == ADDR_FLAG_BASE[7:5]) begin
                rd_val = flag_r[araddr[4:2]];
                rd_ok  = 1'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // bus channel state
    // ----------------------------------------------------------------

    // next values of the held request and the two answers
    always_comb begin
        aw_held_nxt = aw_held_r;
        awaddr_nxt  = awaddr_r;
        w_held_nxt  = w_held_r;
        wdata_nxt   = wdata_r;
        wstrb0_nxt  = wstrb0_r;
        bvalid_nxt  = bvalid_r && !bready;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r && !rready;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (aw_take) begin
            aw_held_nxt = 1'h1;
            awaddr_nxt  = awaddr;
        end
        if (w_take) begin
            w_held_nxt = 1'h1;
            wdata_nxt  = wdata[7:0];
            wstrb0_nxt = wstrb[0];
        end
        if (wr_go) begin
            aw_held_nxt = 1'h0;
            w_held_nxt  = 1'h0;
            bvalid_nxt  = 1'h1;
            bresp_nxt   = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (ar_take) begin
            rvalid_nxt = 1'h1;
            rdata_nxt  = {24'h000000, rd_val};
            rresp_nxt  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // register the bus channel state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'h0;
            awaddr_r  <= 8'h00;
            w_held_r  <= 1'h0;
            wdata_r   <= 8'h00;
            wstrb0_r  <= 1'h0;
            bvalid_r  <= 1'h0;
            bresp_r   <= RESP_OKAY;
            rvalid_r  <= 1'h0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            awaddr_r  <= awaddr_nxt;
            w_held_r  <= w_held_nxt;
            wdata_r   <= wdata_nxt;
            wstrb0_r  <= wstrb0_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    assign bvalid = bvalid_r;
    assign bresp  = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata  = rdata_r;
    assign rresp  = rresp_r;

    // ----------------------------------------------------------------
    // flag, enable and interrupt state
    // ----------------------------------------------------------------

    // hardware set is or-ed in after the write, so an event in the
    // cycle of a clearing write survives it
    always_comb begin
        ctrl_nxt   = wr_ctrl ? (wd & CTRL_IMPL) : ctrl_r;
        mask_nxt   = wr_mask ? wd : mask_r;
        status_nxt = rd_status ? STAT_RST : status_r;
        for (int g = 0; g < NUM_GRP; g++) begin
            flag_nxt[g] = wr_flag_hit[g] ? wd : flag_r[g];
            flag_nxt[g] = (flag_nxt[g] | evt[g]) & impl[g];
            en_nxt[g]   = (wr_en_hit[g] ? wd : en_r[g]) & impl[g];
            status_nxt[g] = status_nxt[g] | (|evt[g]);
            grp_hit[g]  = |(flag_nxt[g] & en_nxt[g]);
        end
        // group 0 holds core events and skips the peripheral enable
        core_irq_nxt = ctrl_nxt[GLOBAL_EN_BIT]
                    && (grp_hit[0] || (ctrl_nxt[PERIPH_EN_BIT] && (|grp_hit[NUM_GRP-1:1])));
        irq_nxt = |(status_nxt & mask_nxt);
    end

    // register flags, enables and interrupt outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int g = 0; g < NUM_GRP; g++) begin
                flag_r[g] <= FLAG_RST;
                en_r[g]   <= EN_RST;
            end
            ctrl_r     <= CTRL_RST;
            status_r   <= STAT_RST;
            mask_r     <= MASK_RST;
            core_irq_r <= 1'h0;
            irq_r      <= 1'h0;
        end else begin
            for (int g = 0; g < NUM_GRP; g++) begin
                flag_r[g] <= flag_nxt[g];
                en_r[g]   <= en_nxt[g];
            end
            ctrl_r     <= ctrl_nxt;
            status_r   <= status_nxt;
            mask_r     <= mask_nxt;
            core_irq_r <= core_irq_nxt;
            irq_r      <= irq_nxt;
        end
    end

    assign core_irq_req = core_irq_r;
    assign irq          = irq_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_ext_set;
        @(posedge aclk) disable iff (!aresetn)
        ext_evt[0] && en_r[0] == 8'h00 |=> flag_r[0][0];
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("event did not set flag");

    property p_cap_mode;
        @(posedge aclk) disable iff (!aresetn)
        capture_unit_mode[1:0] == 2'h1 && capture_evt[0] && !wr_flag_hit[CAP_GRP]
        |=> flag_r[CAP_GRP][0];
    endproperty
    a_cap_mode: assert property (p_cap_mode) else $error("capture flag missed");

    property p_cap_off;
        @(posedge aclk) disable iff (!aresetn)
        capture_unit_mode[1:0] == 2'h0 && !flag_r[CAP_GRP][0] && !wr_flag_hit[CAP_GRP]
        |=> !flag_r[CAP_GRP][0];
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("idle unit set flag");

    property p_sticky;
        @(posedge aclk) disable iff (!aresetn)
        flag_r[MISC_GRP][OSC_BIT] && !wr_flag_hit[MISC_GRP] |=> flag_r[MISC_GRP][OSC_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");

    property p_osc;
        @(posedge aclk) disable iff (!aresetn)
        osc_rollover |=> flag_r[MISC_GRP][OSC_BIT]
                         ##1 (flag_r[MISC_GRP][OSC_BIT] || $past(wr_flag_hit[MISC_GRP]));
    endproperty
    a_osc: assert property (p_osc) else $error("rollover flag missed");

    property p_wave;
        @(posedge aclk) disable iff (!aresetn)
        waveform_shutdown |=> flag_r[MISC_GRP][WAVE_BIT];
    endproperty
    a_wave: assert property (p_wave) else $error("shutdown flag missed");

    property p_unimpl;
        @(posedge aclk) disable iff (!aresetn)
        (flag_r[MISC_GRP] & ~GRP_IMPL[MISC_GRP]) == 8'h00
        && (en_r[CAP_GRP] & ~GRP_IMPL[CAP_GRP]) == 8'h00;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

    property p_reset;
        @(posedge aclk)
        !aresetn |=> flag_r[CAP_GRP] == 8'h00 && flag_r[MISC_GRP] == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("flag not cleared by reset");

    property p_variant;
        @(posedge aclk) disable iff (!aresetn)
        impl[CMP2_GRP][CMP2_BIT] == LARGE_VARIANT
        && (LARGE_VARIANT || (!flag_r[CMP2_GRP][CMP2_BIT] && !en_r[CMP2_GRP][CMP2_BIT]));
    endproperty
    a_variant: assert property (p_variant) else $error("absent comparator bit set");

    property p_mem;
        @(posedge aclk) disable iff (!aresetn)
        memory_done |=> flag_r[MISC_GRP][MEM_BIT];
    endproperty
    a_mem: assert property (p_mem) else $error("memory done flag missed");

    property p_core;
        @(posedge aclk) disable iff (!aresetn)
        ##1 core_irq_req == (ctrl_r[GLOBAL_EN_BIT] && (|(flag_r[0] & en_r[0])
            || (ctrl_r[PERIPH_EN_BIT] && |(flag_r[MISC_GRP] & en_r[MISC_GRP]))
            || (ctrl_r[PERIPH_EN_BIT] && |(flag_r[CAP_GRP] & en_r[CAP_GRP]))
            || (ctrl_r[PERIPH_EN_BIT] && |(flag_r[1] & en_r[1]))
            || (ctrl_r[PERIPH_EN_BIT] && |(flag_r[2] & en_r[2]))
            || (ctrl_r[PERIPH_EN_BIT] && |(flag_r[3] & en_r[3]))
            || (ctrl_r[PERIPH_EN_BIT] && |(flag_r[4] & en_r[4]))
            || (ctrl_r[PERIPH_EN_BIT] && |(flag_r[5] & en_r[5]))));
    endproperty
    a_core: assert property (p_core) else $error("core request mismatch");

endmodule

// file: verification/pifb_evt_model.sv
`timescale 1ns/10ps
module pifb_evt_model
    import pifb_pkg::*;
(
    input  wire logic              aclk,
    output logic [8*NUM_EXT-1:0]   ext_evt,
    output logic [2*NUM_CAP-1:0]   capture_unit_mode,
    output logic [NUM_CAP-1:0]     capture_evt,
    output logic [NUM_CAP-1:0]     match_evt,
    output logic [NUM_CAP-1:0]     pwm_trail_evt,
    output logic                   memory_done,
    output logic                   osc_rollover,
    output logic                   waveform_shutdown
);
    // ----------------------------------------------------------------
    // event lines, quiet low between pulses
    // ----------------------------------------------------------------
    logic [56:0]          ev_r = '0;
    logic [2*NUM_CAP-1:0] mode_r = '0;

    // one flat vector keeps the bench's event table a plain index
    assign ext_evt           = ev_r[47:0];
    assign capture_evt       = ev_r[49:48];
    assign match_evt         = ev_r[51:50];
    assign pwm_trail_evt     = ev_r[53:52];
    assign memory_done       = ev_r[54];
    assign osc_rollover      = ev_r[55];
    assign waveform_shutdown = ev_r[56];
    assign capture_unit_mode = mode_r;

    // single-cycle pulse, so a level event cannot mask a later clear
    task automatic fire(input int idx);
        @(posedge aclk);
        ev_r[idx] <= 1'b1;
        @(posedge aclk);
        ev_r[idx] <= 1'b0;
        // one more edge, so registered flags and requests already show it
        @(posedge aclk);
    endtask

    task automatic set_mode(input int u, input int m);
        @(posedge aclk);
        mode_r[2*u+:2] <= 2'(m);
    endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import pifb_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                 aclk, aresetn, awvalid, awready, wvalid, wready;
    logic                 bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0]           awaddr, araddr;
    logic [31:0]          wdata, rdata, rd_v;
    logic [3:0]           wstrb, strb;
    logic [1:0]           bresp, rresp, rs_v;
    logic [8*NUM_EXT-1:0] ext_evt;
    logic [2*NUM_CAP-1:0] cmode;
    logic [NUM_CAP-1:0]   cap_e, mat_e, pwm_e;
    logic                 mem_e, osc_e, wav_e, core_irq_req, irq;
    int                   miscompares = 0;
    int                   compares = 0;

    pifb_flag_bank #(.LARGE_VARIANT(1'b1)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_evt(ext_evt),
        .capture_unit_mode(cmode), .capture_evt(cap_e), .match_evt(mat_e),
        .pwm_trail_evt(pwm_e), .memory_done(mem_e), .osc_rollover(osc_e),
        .waveform_shutdown(wav_e), .core_irq_req(core_irq_req), .irq(irq));

    pifb_evt_model u_src (
        .aclk(aclk), .ext_evt(ext_evt), .capture_unit_mode(cmode),
        .capture_evt(cap_e), .match_evt(mat_e), .pwm_trail_evt(pwm_e),
        .memory_done(mem_e), .osc_rollover(osc_e), .waveform_shutdown(wav_e));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic summarize;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // a lost handshake must end the run, not hang it
    task automatic hang(input string nm);
        miscompares++;
        $display("mismatch %s expected answer seen none", nm);
        summarize();
    endtask

    // reset level changes just after an edge, like every other input
    task automatic set_rst(input logic v);
        @(posedge aclk);
        aresetn <= v;
    endtask

    // aw and w offered together, each dropped at its own taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        bit awd;
        bit wd;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        wstrb <= strb;
        awd = 0; wd = 0; n = 0;
        while (1) begin
            @(posedge aclk);
            n++;
            if (!awd && awready === 1'b1) begin awd = 1; awvalid <= 1'b0; end
            if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
            if (bvalid === 1'b1) begin r = bresp; bready <= 1'b0; break; end
            if (n > 200) hang("write");
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        bit ard;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        ard = 0; n = 0;
        while (1) begin
            @(posedge aclk);
            n++;
            if (!ard && arready === 1'b1) begin ard = 1; arvalid <= 1'b0; end
            if (rvalid === 1'b1) begin d = rdata; r = rresp; rready <= 1'b0; break; end
            if (n > 200) hang("read");
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        rd(a, rd_v, rs_v);
        chk(nm, e, rd_v);
    endtask

    function automatic logic [7:0] fa(input int g);
        return ADDR_FLAG_BASE + 8'(4 * g);
    endfunction

    function automatic logic [7:0] ea(input int g);
        return ADDR_EN_BASE + 8'(4 * g);
    endfunction

    // ----------------------------------------------------------------
    // clock and main sequence
    // ----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    initial begin : main
        int g; int b; int m; int k; int u;
        logic [31:0] e;
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0;
        wdata = '0; strb = 4'hF; wstrb = strb;
        repeat (15) @(posedge aclk);
        set_rst(1'b1);
        // reset values, then write-all-ones shows which bits exist
        rdchk(ADDR_CTRL, 32'h0, "ctrl_rst");
        rdchk(ADDR_STATUS, 32'h0, "status_rst");
        rdchk(ADDR_MASK, 32'h0, "mask_rst");
        wr(ADDR_CTRL, 32'hFF, rs_v);
        rdchk(ADDR_CTRL, {24'h0, CTRL_IMPL}, "ctrl_impl");
        wr(ADDR_CTRL, 32'h0, rs_v);
        for (g = 0; g < NUM_GRP; g++) begin
            rdchk(fa(g), 32'h0, "flag_rst");
            rdchk(ea(g), 32'h0, "en_rst");
            wr(fa(g), 32'hFF, rs_v);
            rdchk(fa(g), {24'h0, GRP_IMPL[g]}, "flag_impl");
            wr(fa(g), 32'h0, rs_v);
            rdchk(fa(g), 32'h0, "flag_clr");
            wr(ea(g), 32'hFF, rs_v);
            rdchk(ea(g), {24'h0, GRP_IMPL[g]}, "en_impl");
            wr(ea(g), 32'h0, rs_v);
        end
        // every external event line, enables and global enable all off
        for (g = 0; g < NUM_EXT; g++) begin
            for (b = 0; b < 8; b++) begin
                u_src.fire(8 * g + b);
                e = {24'h0, GRP_IMPL[g] & (8'h01 << b)};
                rdchk(fa(g), e, "ext_flag");
                wr(fa(g), 32'h0, rs_v);
            end
        end
        // misc group: flags stick until written zero
        u_src.fire(55);
        rdchk(fa(MISC_GRP), 32'h10, "osc_flag");
        repeat (20) @(posedge aclk);
        rdchk(fa(MISC_GRP), 32'h10, "osc_sticky");
        u_src.fire(54);
        rdchk(fa(MISC_GRP), 32'h30, "mem_flag");
        u_src.fire(56);
        rdchk(fa(MISC_GRP), 32'h31, "wave_flag");
        wr(fa(MISC_GRP), 32'h20, rs_v);
        rdchk(fa(MISC_GRP), 32'h20, "misc_part_clr");
        wr(fa(MISC_GRP), 32'h0, rs_v);
        rdchk(fa(MISC_GRP), 32'h0, "misc_clr");
        // capture units: only the event of the selected mode sets the flag
        for (u = 0; u < NUM_CAP; u++) begin
            for (m = 0; m < 4; m++) begin
                u_src.set_mode(u, m);
                for (k = 0; k < 3; k++) begin
                    u_src.fire(48 + 2 * k + u);
                    e = (m == k + 1) ? (32'h1 << u) : 32'h0;
                    rdchk(fa(CAP_GRP), e, "cap_flag");
                    wr(fa(CAP_GRP), 32'h0, rs_v);
                end
            end
        end
        // status, mask and irq level
        rd(ADDR_STATUS, rd_v, rs_v);
        u_src.fire(55);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(ADDR_MASK, 32'h80, rs_v);
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        rdchk(ADDR_STATUS, 32'h80, "status_evt");
        chk("irq_after_clr", 32'h0, {31'h0, irq});
        rdchk(ADDR_STATUS, 32'h0, "status_clr");
        // a write with byte lane 0 off is answered okay and changes nothing
        strb = 4'h0;
        wr(ADDR_MASK, 32'h0, rs_v);
        chk("wstrb_resp", {30'h0, RESP_OKAY}, {30'h0, rs_v});
        rdchk(ADDR_MASK, 32'h80, "wstrb_ignored");
        strb = 4'hF;
        // core request gating, pending flag cleared before enabling
        wr(fa(MISC_GRP), 32'h0, rs_v);
        wr(ea(MISC_GRP), 32'h10, rs_v);
        u_src.fire(55);
        chk("core_no_gie", 32'h0, {31'h0, core_irq_req});
        wr(ADDR_CTRL, 32'h80, rs_v);
        chk("core_no_peripheral_irq_enable", 32'h0, {31'h0, core_irq_req});
        wr(ADDR_CTRL, 32'hC0, rs_v);
        chk("core_on", 32'h1, {31'h0, core_irq_req});
        wr(fa(MISC_GRP), 32'h0, rs_v);
        chk("core_flag_clr", 32'h0, {31'h0, core_irq_req});
        wr(ADDR_CTRL, 32'h80, rs_v);
        wr(fa(0), 32'h0, rs_v);
        wr(ea(0), 32'h01, rs_v);
        u_src.fire(0);
        chk("core_grp0", 32'h1, {31'h0, core_irq_req});
        // unmapped and misaligned places
        wr(8'h10, 32'hFF, rs_v);
        chk("wr_unmapped", {30'h0, RESP_SLVERR}, {30'h0, rs_v});
        rd(8'h42, rd_v, rs_v);
        chk("rd_misalign", {30'h0, RESP_SLVERR}, {30'h0, rs_v});
        chk("rd_misalign_data", 32'h0, rd_v);
        // a reset in mid-run clears flags and control set by software
        wr(fa(MISC_GRP), 32'hFF, rs_v);
        set_rst(1'b0);
        repeat (2) @(posedge aclk);
        set_rst(1'b1);
        rdchk(fa(MISC_GRP), 32'h0, "flag_rst_mid");
        rdchk(ADDR_CTRL, 32'h0, "ctrl_rst_mid");
        summarize();
    end
endmodule
